// [rtl/din_map.vh]
`ifndef DIN_MAP_VH
`define DIN_MAP_VH
// register indices (word address = index)
`define REG_CTRL 8'h00
`define REG_LEVEL 8'h01
`define REG_LATCH 8'h02
`define REG_IRQ_STAT 8'h03
`define REG_IRQ_MASK 8'h04
`define REG_CMD 8'h05
`define REG_CH_BASE 8'h10
`define CH_STRIDE 4
`define CH_CFG 2'h0
`define CH_WIDTH 2'h1
`define CH_COUNT 2'h2
`define CH_FREQ 2'h3
// channel cfg fields
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 2
`define CFG_INV 3
`define CFG_FILT 4
`define CFG_RETAIN 5
`define CFG_RUN 6
// command bits, per channel base
`define CMD_COMMIT 0
`define CMD_CLR_CNT 8
`define CMD_CLR_LAT 16
// modes
`define MODE_LEVEL 3'h0
`define MODE_COUNT 3'h1
`define MODE_RISE 3'h2
`define MODE_FALL 3'h3
`define MODE_FREQ 3'h4
// reset values
`define CFG_RST 7'h00
`define WIDTH_RST 32'h00010001
// timing
`define CLK_HZ 100000000
`define TICK_NS 100000
`define TICK_CYC ((`TICK_NS * (`CLK_HZ / 1000000)) / 1000)
`define GATE_TICKS 10000
`endif

// [rtl/din_filter.v]
`timescale 1ns/1ps
`include "din_map.vh"
module din_filter (
   // clock and reset
   input wire clk,
   input wire rst,
   // conditioning
   input wire tick,
   input wire enable,
   input wire [15:0] min_low,
   input wire [15:0] min_high,
   input wire din,
   output reg dout
);
   reg [15:0] cnt_q;
   always @(posedge clk) begin
      if (rst) begin
         dout <= 1'b0;
         cnt_q <= 16'h0000;
      end else if (!enable) begin
         dout <= din;
         cnt_q <= 16'h0000;
      end else if (din == dout) begin
         cnt_q <= 16'h0000;
      end else if (tick) begin
         // a level must persist for its own minimum width
         if (cnt_q + 16'h0001 >= (din ? min_high : min_low)) begin
            dout <= din;
            cnt_q <= 16'h0000;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule

// [rtl/din_channels.v]
`timescale 1ns/1ps
`include "din_map.vh"
// Function
// - five modes, applied on commit command
// - inversion complements input before processing
// - optional filter rejects short pulses
// - separate min low/high widths, 0.1 ms
// - counter mode counts pulses, readable
// - start/stop; stopped count holds
// - clear command zeroes count
// - inversion and filter apply when counting
// - retain keeps count across warm reset; power_up clears it
// - no retain: count zero at power-up
// - rising edge sets latch until clear
// - falling edge sets latch until clear
// - frequency reported in hertz
module din_channels (
   // clock and reset
   input wire clk,
   input wire rst,
   input wire power_up,
   // field inputs
   input wire [7:0] digital_input_channel,
   // register port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   // status
   output reg [7:0] level_q,
   output reg [7:0] latch_q,
   output reg irq
);
   localparam NCH = 8;
   localparam [31:0] TICK_FULL = `TICK_CYC;
   localparam [31:0] GATE_FULL = `GATE_TICKS;
   localparam [16:0] TICK_CYC = TICK_FULL[16:0];
   localparam [13:0] GATE_TICKS = GATE_FULL[13:0];
   reg [16:0] div_q;
   reg tick_q;
   reg [13:0] gate_q;
   reg gate_end_q;
   reg [7:0] mask_q;
   reg [7:0] stat_q;
   wire [7:0] filt;
   wire [7:0] ev_latch;
   wire [7:0] ev_gate;
   reg [7:0] prev_q;
   reg [6:0] cfg_q [0:NCH-1];
   reg [2:0] mode_q [0:NCH-1];
   reg [31:0] width_q [0:NCH-1];
   reg [31:0] count_q [0:NCH-1];
   reg [31:0] fcnt_q [0:NCH-1];
   reg [31:0] freq_q [0:NCH-1];
   wire cmd_wr = wr && (addr == `REG_CMD);
   wire ch_sel = (addr >= `REG_CH_BASE) && (addr < `REG_CH_BASE + NCH * `CH_STRIDE);
   wire [7:0] ch_off = addr - `REG_CH_BASE;
   wire [2:0] ch_idx = ch_off[4:2];
   wire [1:0] ch_reg = ch_off[1:0];

   // 0.1 ms tick and frequency gate of 1 s, so counts read directly as hertz
   always @(posedge clk) begin
      if (rst) begin
         div_q <= 17'h00000;
         tick_q <= 1'b0;
         gate_q <= 14'h0000;
         gate_end_q <= 1'b0;
      end else begin
         tick_q <= (div_q == TICK_CYC - 17'h00001);
         div_q <= (div_q == TICK_CYC - 17'h00001) ? 17'h00000 : div_q + 17'h00001;
         gate_end_q <= 1'b0;
         if (tick_q) begin
            if (gate_q == GATE_TICKS - 14'h0001) begin
               gate_q <= 14'h0000;
               gate_end_q <= 1'b1;
            end else begin
               gate_q <= gate_q + 14'h0001;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         wire inv_in = digital_input_channel[g] ^ cfg_q[g][`CFG_INV];
         wire rise = filt[g] & ~prev_q[g];
         wire fall = ~filt[g] & prev_q[g];
         wire sel = ch_sel && (ch_idx == g);
         din_filter u_filt (
            .clk(clk),
            .rst(rst),
            .tick(tick_q),
            .enable(cfg_q[g][`CFG_FILT]),
            .min_low(width_q[g][15:0]),
            .min_high(width_q[g][31:16]),
            .din(inv_in),
            .dout(filt[g])
         );
         assign ev_latch[g] = ((mode_q[g] == `MODE_RISE) && rise) || ((mode_q[g] == `MODE_FALL) && fall);
         assign ev_gate[g] = gate_end_q && (mode_q[g] == `MODE_FREQ);
         always @(posedge clk) begin
            if (rst) begin
               cfg_q[g] <= `CFG_RST;
               mode_q[g] <= `MODE_LEVEL;
               width_q[g] <= `WIDTH_RST;
               fcnt_q[g] <= 32'h00000000;
               freq_q[g] <= 32'h00000000;
               prev_q[g] <= 1'b0;
               latch_q[g] <= 1'b0;
               level_q[g] <= 1'b0;
            end else begin
               prev_q[g] <= filt[g];
               level_q[g] <= filt[g];
               if (wr && sel && ch_reg == `CH_CFG)
                  cfg_q[g] <= wdata[6:0];
               if (wr && sel && ch_reg == `CH_WIDTH) begin
                  // zero widths are outside the legal range; held at 1
                  width_q[g][15:0] <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
                  width_q[g][31:16] <= (wdata[31:16] == 16'h0000) ? 16'h0001 : wdata[31:16];
               end
               if (cmd_wr && wdata[`CMD_COMMIT + g])
                  mode_q[g] <= cfg_q[g][`CFG_MODE_MSB:`CFG_MODE_LSB];
               // set wins over clear
               if (ev_latch[g])
                  latch_q[g] <= 1'b1;
               else if (cmd_wr && wdata[`CMD_CLR_LAT + g])
                  latch_q[g] <= 1'b0;
               if (mode_q[g] != `MODE_FREQ) begin
                  fcnt_q[g] <= 32'h00000000;
               end else if (gate_end_q) begin
                  freq_q[g] <= fcnt_q[g] + {31'h00000000, rise};
                  fcnt_q[g] <= 32'h00000000;
               end else if (rise) begin
                  fcnt_q[g] <= fcnt_q[g] + 32'h00000001;
               end
            end
         end
         // counter survives a warm reset when retained and is cleared by it otherwise; power_up always clears it
         // retain copied outside reset, since cfg is cleared on the first reset edge
         reg keep_q;
         always @(posedge clk) begin
            if (power_up) begin
               count_q[g] <= 32'h00000000;
               keep_q <= 1'b0;
            end else if (rst) begin
               if (!keep_q)
                  count_q[g] <= 32'h00000000;
               // retained count kept as is
            end else begin
               keep_q <= cfg_q[g][`CFG_RETAIN];
               if (cmd_wr && wdata[`CMD_CLR_CNT + g])
                  count_q[g] <= 32'h00000000;
               else if (mode_q[g] == `MODE_COUNT && cfg_q[g][`CFG_RUN] && rise)
                  count_q[g] <= count_q[g] + 32'h00000001;
            end
         end
      end
   endgenerate

   // interrupts: read of status clears, new events win
   always @(posedge clk) begin
      if (rst) begin
         stat_q <= 8'h00;
         mask_q <= 8'h00;
         irq <= 1'b0;
      end else begin
         if (wr && addr == `REG_IRQ_MASK)
            mask_q <= wdata[7:0];
         stat_q <= (rd && addr == `REG_IRQ_STAT ? 8'h00 : stat_q) | ev_latch | ev_gate;
         irq <= |(stat_q & mask_q);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         if (ch_sel) begin
            case (ch_reg)
               `CH_CFG: rdata <= {25'h0000000, cfg_q[ch_idx]};
               `CH_WIDTH: rdata <= width_q[ch_idx];
               `CH_COUNT: rdata <= count_q[ch_idx];
               `CH_FREQ: rdata <= freq_q[ch_idx];
               default: rdata <= 32'h00000000;
            endcase
         end else begin
            case (addr)
               `REG_CTRL: rdata <= {24'h000000, mask_q};
               `REG_LEVEL: rdata <= {24'h000000, level_q};
               `REG_LATCH: rdata <= {24'h000000, latch_q};
               `REG_IRQ_STAT: rdata <= {24'h000000, stat_q};
               `REG_IRQ_MASK: rdata <= {24'h000000, mask_q};
               default: rdata <= 32'h00000000;
            endcase
         end
      end else begin
         rdata <= 32'h00000000;
      end
   end
endmodule

// [bench/din_channels_props.sv]
`timescale 1ns/1ps
`include "din_map.vh"
module din_channels_props (
   // clock and reset
   input wire clk,
   input wire rst,
   input wire power_up,
   // field and register port
   input wire [7:0] digital_input_channel,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   // results
   input wire [31:0] rdata,
   input wire [7:0] level_q,
   input wire [7:0] latch_q,
   input wire irq
);
   // shadow of channel 0 setup, rebuilt from bus writes
   logic [6:0] cfg_q;
   logic [2:0] mode_q;
   logic [2:0] calm_q;
   logic mask_q;
   logic din_q;
   wire clr0 = wr && addr == 8'h05 && wdata[16];
   always @(posedge clk) begin
      din_q <= digital_input_channel[0];
      if (rst) begin
         cfg_q <= 7'h00;
         mode_q <= 3'h0;
         mask_q <= 1'b0;
         calm_q <= 3'h0;
      end else begin
         // any write may move the conditioning, so settling restarts
         calm_q <= (wr || digital_input_channel[0] != din_q) ? 3'h0 : calm_q + {2'h0, calm_q != 3'h7};
         if (wr && addr == 8'h10)
            cfg_q <= wdata[6:0];
         if (wr && addr == 8'h04)
            mask_q <= wdata[0];
         if (wr && addr == 8'h05 && wdata[0])
            mode_q <= cfg_q[2:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst || power_up);
   a_rdata_idle_zero: assert property (!rd |=> rdata == 32'h0) else $error("read data not zero");
   a_level_follows_input: assert property (!cfg_q[4] && calm_q == 3'h7
      |-> level_q[0] == (digital_input_channel[0] ^ cfg_q[3])) else $error("level mismatch");
   a_latch_holds: assert property (latch_q[0] && !(wr && addr == 8'h05) |=> latch_q[0]) else $error("latch lost");
   a_latch_clears: assert property (clr0 && calm_q == 3'h7 |-> ##[1:2] !latch_q[0]) else $error("latch stuck");
   a_rise_sets_latch: assert property (mode_q == `MODE_RISE && $rose(level_q[0])
      |-> ##[0:2] latch_q[0]) else $error("rise not latched");
   a_fall_sets_latch: assert property (mode_q == `MODE_FALL && $fell(level_q[0])
      |-> ##[0:2] latch_q[0]) else $error("fall not latched");
   a_latch_raises_irq: assert property (mask_q && $rose(latch_q[0]) |-> ##[0:2] irq) else $error("no irq");
   a_level_mode_quiet: assert property (mode_q == `MODE_LEVEL && !latch_q[0] |=> !latch_q[0])
      else $error("latch in level mode");
   cover property (mode_q == `MODE_RISE && $rose(latch_q[0]));
   cover property (mode_q == `MODE_FALL && $rose(latch_q[0]));
   cover property (mask_q && irq);
endmodule
bind din_channels din_channels_props din_channels_props_i (.clk(clk), .rst(rst), .power_up(power_up),
   .digital_input_channel(digital_input_channel), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .level_q(level_q), .latch_q(latch_q), .irq(irq));

// [bench/field_src.sv]
`timescale 1ns/1ps
module field_src (
   // clock
   input wire clk,
   // field lines, push-pull so idle simply holds low
   output logic [7:0] lines
);
   initial lines = 8'h00;
   task automatic pulse(input int ch, input int n);
      for (int i = 0; i < n; i++) begin
         lines[ch] <= 1'b1;
         repeat (4) @(posedge clk);
         lines[ch] <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic hold(input int ch, input logic v, input int n);
      lines[ch] <= v;
      repeat (n) @(posedge clk);
   endtask
endmodule

// [bench/tb_din_channels.sv]
`timescale 1ns/1ps
module tb_din_channels;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic power_up = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   wire [7:0] din;
   wire [7:0] level_q;
   wire [7:0] latch_q;
   wire [31:0] rdata;
   wire irq;
   int bad_count = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   field_src field_src_i (.clk(clk), .lines(din));
   din_channels din_channels_i (.clk(clk), .rst(rst), .power_up(power_up), .digital_input_channel(din),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .level_q(level_q), .latch_q(latch_q), .irq(irq));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask
   task automatic t_reset;
      rd_chk("cfg", 8'h10, 32'h0);
      rd_chk("widths", 8'h11, 32'h00010001);
      wr_reg(8'h15, 32'h0);
      rd_chk("zero widths", 8'h15, 32'h00010001);
      wr_reg(8'h11, 32'hFFFF0001);
      rd_chk("max widths", 8'h11, 32'hFFFF0001);
      rd_chk("unmapped", 8'h0F, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_count;
      wr_reg(8'h18, 32'h41);
      // mode still level until committed, so nothing counts
      field_src_i.pulse(2, 1);
      rd_chk("uncommitted count", 8'h1A, 32'h0);
      wr_reg(8'h05, 32'h04);
      field_src_i.pulse(2, 3);
      rd_chk("count", 8'h1A, 32'h3);
      wr_reg(8'h18, 32'h01);
      wr_reg(8'h05, 32'h04);
      field_src_i.pulse(2, 2);
      rd_chk("stopped count", 8'h1A, 32'h3);
      wr_reg(8'h05, 32'h400);
      rd_chk("cleared count", 8'h1A, 32'h0);
      $display("test count done");
   endtask
   task automatic t_filter;
      wr_reg(8'h1D, 32'h00020001);
      wr_reg(8'h1C, 32'h51);
      wr_reg(8'h05, 32'h08);
      // glitches far shorter than one tick
      field_src_i.pulse(3, 2);
      rd_chk("glitch count", 8'h1E, 32'h0);
      // two ticks of high needed, so half a tick is still rejected
      field_src_i.hold(3, 1'b1, 5000);
      chk("early high", 32'h0, {31'h0, level_q[3]});
      field_src_i.hold(3, 1'b1, 20000);
      chk("filtered high", 32'h1, {31'h0, level_q[3]});
      field_src_i.hold(3, 1'b0, 12000);
      rd_chk("filtered count", 8'h1E, 32'h1);
      $display("test filter done");
   endtask
   task automatic t_freq;
      wr_reg(8'h20, 32'h04);
      wr_reg(8'h05, 32'h10);
      field_src_i.pulse(4, 5);
      // the 1 s gate cannot close inside this run, so nothing is reported yet
      rd_chk("freq before gate", 8'h23, 32'h0);
      rd_chk("no gate event", 8'h03, 32'h1);
      $display("test freq done");
   endtask
   task automatic t_latch;
      wr_reg(8'h04, 32'h1);
      wr_reg(8'h10, 32'h02);
      wr_reg(8'h05, 32'h01);
      field_src_i.pulse(0, 1);
      chk("rise latch", 32'h1, {24'h0, latch_q});
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk("status", 8'h03, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq after read", 32'h0, {31'h0, irq});
      wr_reg(8'h05, 32'h10000);
      repeat (3) @(posedge clk);
      chk("cleared latch", 32'h0, {24'h0, latch_q});
      wr_reg(8'h10, 32'h0B);
      wr_reg(8'h05, 32'h01);
      repeat (8) @(posedge clk);
      // the polarity flip itself may latch, so start clean
      wr_reg(8'h05, 32'h10000);
      repeat (3) @(posedge clk);
      chk("inverted level", 32'h1, {24'h0, level_q});
      field_src_i.pulse(0, 1);
      rd_chk("fall latch", 8'h02, 32'h1);
      $display("test latch done");
   endtask
   task automatic t_retain;
      wr_reg(8'h18, 32'h61);
      wr_reg(8'h05, 32'h04);
      field_src_i.pulse(2, 2);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd_chk("kept count", 8'h1A, 32'h2);
      rst <= 1'b1;
      power_up <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      power_up <= 1'b0;
      rd_chk("power-up count", 8'h1A, 32'h0);
      $display("test retain done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      power_up <= 1'b0;
      t_reset;
      t_count;
      t_latch;
      t_filter;
      t_freq;
      t_retain;
      tally_and_finish;
   end
   // about 40000 cycles of work, the filter test dominates
   initial begin
      #600000;
      bad_count++;
      tally_and_finish;
   end
endmodule
